// ===== include/mac_stat_defines.svh
`ifndef MAC_STAT_DEFINES_SVH
`define MAC_STAT_DEFINES_SVH

// register byte offsets
`define OFS_ALIGNMENT_ERRORS       8'h00
`define OFS_DEFERRED_TX            8'h04
`define OFS_LATE_COLLISIONS        8'h08
`define OFS_EXCESS_COLLISIONS      8'h0c
`define OFS_TX_UNDERRUNS           8'h10
`define OFS_CARRIER_SENSE_ERRORS   8'h14
`define OFS_RX_RESOURCE_ERRORS     8'h18
`define OFS_RX_OVERRUNS            8'h1c
`define OFS_RX_SYMBOL_ERRORS       8'h20
`define OFS_OVERSIZE_FRAMES        8'h24
`define OFS_RX_JABBERS             8'h28
`define OFS_UNDERSIZE_FRAMES       8'h2c
`define OFS_HEARTBEAT_TEST_ERRORS  8'h30
`define OFS_LENGTH_MISMATCH        8'h34

// control bit positions
`define CTL_STAT_WRITE_EN_BIT      7
`define CFG_BIG_FRAMES_BIT         8
`define CFG_LENGTH_CHECK_BIT       16

// frame length limits in bytes
`define LEN_MIN_FRAME              14'd64
`define LEN_MAX_FRAME              14'd1518
`define LEN_MAX_BIG_FRAME          14'd1536
`define LEN_TYPE_THRESHOLD         16'h0600

// heartbeat window: 96 bit times at 100 Mb/s is 960 ns
`define HEARTBEAT_WINDOW_NS        960
`define CLK_PERIOD_NS              4
`define HEARTBEAT_WINDOW_CYC       (`HEARTBEAT_WINDOW_NS / `CLK_PERIOD_NS)

`define STAT_RESET_VALUE           16'h0000

`endif

// ===== include/mac_stat_pkg.sv
package mac_stat_pkg;

   typedef struct packed {
      logic        done;          // one-cycle end-of-frame strobe
      logic        deferred;      // first attempt deferred by carrier
      logic        collided;      // any collision on this frame
      logic        late_col;      // collision after slot time
      logic        excess_col;    // abandoned after 16 collisions
      logic        underrun;      // transmit dma underran
      logic        carrier_err;   // carrier never seen or dropped
   } tx_status_s;

   typedef struct packed {
      logic        done;          // one-cycle end-of-frame strobe
      logic [13:0] length;        // frame length in bytes
      logic        odd_bits;      // not a whole number of bytes
      logic        crc_bad;       // crc fails on truncated frame
      logic        symbol_err;    // rx_er seen during frame
      logic        addr_match;    // address recognised
      logic        no_buffer;     // no receive buffer free
      logic        overrun;       // receive dma overrun
      logic [15:0] len_field;     // length/type value, bytes 13 and 14
   } rx_status_s;

   typedef enum {
      HB_IDLE,
      HB_WAIT
   } hb_state_e;

endpackage

// ===== logic/mac_statistics_counters.sv
// Function
// - alignment count: odd bits, bad crc, valid length
// - alignment count also on symbol error with odd bits, valid length
// - deferred count: first attempt deferred by carrier sense
// - deferred count skips collided or underrun frames
// - late collision count on collision after 512-bit slot time
// - excessive collision count: frame abandoned after 16 collisions
// - underrun count: frame lost to transmit dma underrun
// - underrun frame increments no other counter
// - carrier sense error: clean frame, carrier missing or dropped
// - carrier sense error only in half duplex, no side effects
// - resource error: matched frame with no receive buffer
// - overrun count: recognised frame dropped by dma overrun
// - symbol error count: rx_er during reception
// - symbol error adds alignment count with odd bits and valid length, or jabber count if too long
// - oversize count: long frame without errors
// - jabber count: long frame with errors
// - undersize count: short frame without errors
// - heartbeat error: no col within 96 bit times of tx_en fall, half duplex only
// - length mismatch: measured length below length field
// - length check only while config bit 16 set
// - no mismatch for type values or oversize frames
// - counters clear on read and saturate
// - receive counters only while receive enabled
// - writes only while control bit 7 set
`include "mac_stat_defines.svh"

module mac_statistics_counters
   import mac_stat_pkg::*;
#(
   parameter int HB_CYCLES = `HEARTBEAT_WINDOW_CYC
) (
   input  wire logic        clk_sys,        // system clock
   input  wire logic        rst,            // synchronous reset, high
   input  wire logic        ce,             // clock enable
   input  wire logic [7:0]  addr,           // register byte address
   input  wire logic [31:0] wdata,          // write data
   input  wire logic        wr,             // write strobe
   input  wire logic        rd,             // read strobe
   output      logic [31:0] rdata,          // read data, cycle after rd
   input  wire logic [31:0] net_ctrl,       // network control register
   input  wire logic [31:0] net_cfg,        // network configuration register
   input  wire logic        rx_enable,      // receive enable bit
   input  wire logic        half_duplex,    // half duplex operation
   input  wire tx_status_s  tx_stat,        // transmit frame outcome
   input  wire rx_status_s  rx_stat,        // receive frame outcome
   input  wire logic        tx_en_pin,      // mii tx_en
   input  wire logic        col_pin         // mii col, asynchronous
);

   localparam int NCNT = 14;

   // ****************************************
   // counter storage
   // ****************************************
   logic [15:0] cnt [NCNT];
   logic [NCNT-1:0] inc;
   logic [4:0]  widths [NCNT];
   logic [3:0]  sel;
   logic        sel_ok;

   function automatic logic [15:0] sat_mask(input logic [4:0] w);
      sat_mask = (w == 5'd16) ? 16'hffff : 16'h00ff;
   endfunction

   assign widths = '{5'd8, 5'd16, 5'd8, 5'd8, 5'd8, 5'd8, 5'd16,
                     5'd8, 5'd8, 5'd8, 5'd8, 5'd8, 5'd8, 5'd8};

   // ****************************************
   // address decode
   // ****************************************
   always_comb begin
      sel    = 4'd0;
      sel_ok = 1'b1;
      if (addr == `OFS_ALIGNMENT_ERRORS) begin
         sel = 4'd0;
      end else if (addr == `OFS_DEFERRED_TX) begin
         sel = 4'd1;
      end else if (addr == `OFS_LATE_COLLISIONS) begin
         sel = 4'd2;
      end else if (addr == `OFS_EXCESS_COLLISIONS) begin
         sel = 4'd3;
      end else if (addr == `OFS_TX_UNDERRUNS) begin
         sel = 4'd4;
      end else if (addr == `OFS_CARRIER_SENSE_ERRORS) begin
         sel = 4'd5;
      end else if (addr == `OFS_RX_RESOURCE_ERRORS) begin
         sel = 4'd6;
      end else if (addr == `OFS_RX_OVERRUNS) begin
         sel = 4'd7;
      end else if (addr == `OFS_RX_SYMBOL_ERRORS) begin
         sel = 4'd8;
      end else if (addr == `OFS_OVERSIZE_FRAMES) begin
         sel = 4'd9;
      end else if (addr == `OFS_RX_JABBERS) begin
         sel = 4'd10;
      end else if (addr == `OFS_UNDERSIZE_FRAMES) begin
         sel = 4'd11;
      end else if (addr == `OFS_HEARTBEAT_TEST_ERRORS) begin
         sel = 4'd12;
      end else if (addr == `OFS_LENGTH_MISMATCH) begin
         sel = 4'd13;
      end else begin
         sel_ok = 1'b0;
      end
   end

   // ****************************************
   // transmit classification
   // ****************************************
   logic tx_ok;
   assign tx_ok = tx_stat.done && !tx_stat.underrun;

   // ****************************************
   // receive classification
   // ****************************************
   logic [13:0] max_len;
   logic        valid_len;
   logic        too_long;
   logic        any_err;
   logic        rx_go;

   assign max_len   = net_cfg[`CFG_BIG_FRAMES_BIT] ? `LEN_MAX_BIG_FRAME : `LEN_MAX_FRAME;
   assign valid_len = rx_stat.length >= `LEN_MIN_FRAME && rx_stat.length <= max_len;
   assign too_long  = rx_stat.length > max_len;
   assign any_err   = rx_stat.crc_bad || rx_stat.odd_bits || rx_stat.symbol_err;
   assign rx_go     = rx_stat.done && rx_enable;

   // ****************************************
   // heartbeat window after tx_en falls
   // ****************************************
   logic       col_meta;
   logic       col_sync;
   logic       tx_en_meta;
   logic       tx_en_sync;
   logic       tx_en_prev;
   logic       hb_err;
   hb_state_e  hb_state;
   logic [15:0] hb_cnt;

   // both mii inputs come from the link clock, so double-flop them
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         col_meta   <= 1'b0;
         col_sync   <= 1'b0;
         tx_en_meta <= 1'b0;
         tx_en_sync <= 1'b0;
         tx_en_prev <= 1'b0;
      end else if (ce) begin
         col_meta   <= col_pin;
         col_sync   <= col_meta;
         tx_en_meta <= tx_en_pin;
         tx_en_sync <= tx_en_meta;
         tx_en_prev <= tx_en_sync;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hb_state <= HB_IDLE;
         hb_cnt   <= 16'h0000;
         hb_err   <= 1'b0;
      end else if (ce) begin
         hb_err <= 1'b0;
         case (hb_state)
            HB_IDLE: begin
               if (tx_en_prev && !tx_en_sync && half_duplex) begin
                  hb_state <= HB_WAIT;
                  hb_cnt   <= 16'h0000;
               end
            end
            HB_WAIT: begin
               if (col_sync) begin
                  hb_state <= HB_IDLE;
               end else if (hb_cnt == 16'(HB_CYCLES - 1)) begin
                  hb_err   <= 1'b1;
                  hb_state <= HB_IDLE;
               end else begin
                  hb_cnt <= hb_cnt + 16'h0001;
               end
            end
            default: hb_state <= HB_IDLE;
         endcase
      end
   end

   // ****************************************
   // increment events
   // ****************************************
   always_comb begin
      inc = '0;
      // carrier error touches only its own counter, never gates others
      inc[0]  = rx_go && rx_stat.odd_bits && valid_len
                && (rx_stat.crc_bad || rx_stat.symbol_err);
      inc[1]  = tx_ok && tx_stat.deferred && !tx_stat.collided;
      inc[2]  = tx_ok && tx_stat.late_col;
      inc[3]  = tx_ok && tx_stat.excess_col;
      inc[4]  = tx_stat.done && tx_stat.underrun;
      inc[5]  = tx_ok && !tx_stat.collided && tx_stat.carrier_err
                && half_duplex;
      inc[6]  = rx_go && rx_stat.addr_match && rx_stat.no_buffer;
      inc[7]  = rx_go && rx_stat.addr_match && rx_stat.overrun;
      inc[8]  = rx_go && rx_stat.symbol_err;
      inc[9]  = rx_go && too_long && !any_err;
      inc[10] = rx_go && too_long && any_err;
      inc[11] = rx_go && rx_stat.length < `LEN_MIN_FRAME && !any_err;
      inc[12] = hb_err;
      inc[13] = rx_go && net_cfg[`CFG_LENGTH_CHECK_BIT]
                && rx_stat.len_field < `LEN_TYPE_THRESHOLD && !too_long
                && {2'b00, rx_stat.length} < rx_stat.len_field;
   end

   // ****************************************
   // counters: write, clear on read, saturate
   // ****************************************
   logic wr_allowed;
   assign wr_allowed = net_ctrl[`CTL_STAT_WRITE_EN_BIT];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < NCNT; i++) begin
            cnt[i] <= `STAT_RESET_VALUE;
         end
      end else if (ce) begin
         for (int i = 0; i < NCNT; i++) begin
            if (wr && sel_ok && sel == 4'(i) && wr_allowed) begin
               cnt[i] <= wdata[15:0] & sat_mask(widths[i]);
            end else if (rd && sel_ok && sel == 4'(i)) begin
               // a same-cycle event is kept rather than lost to the clear
               cnt[i] <= inc[i] ? 16'h0001 : `STAT_RESET_VALUE;
            end else if (inc[i] && cnt[i] != sat_mask(widths[i])) begin
               cnt[i] <= cnt[i] + 16'h0001;
            end
         end
      end
   end

   // ****************************************
   // read data
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata <= 32'h0000_0000;
      end else if (ce) begin
         if (rd && sel_ok) begin
            rdata <= {16'h0000, cnt[sel]};
         end else begin
            rdata <= 32'h0000_0000;
         end
      end
   end

endmodule

// ===== dv/mac_stat_assertions.sv
// ********
// register port checker
// ********
module mac_stat_assertions
   import mac_stat_pkg::*;
#(
   parameter int HB_CYCLES = 240
) (
   input wire logic        clk_sys,    // clock
   input wire logic        rst,        // reset
   input wire logic        ce,         // enable
   input wire logic [7:0]  addr,       // address
   input wire logic [31:0] wdata,      // write data
   input wire logic        wr,         // write
   input wire logic        rd,         // read
   input wire logic [31:0] rdata,      // read data
   input wire logic [31:0] net_ctrl,   // control
   input wire logic        rx_enable,  // rx enable
   input wire tx_status_s  tx_stat,    // tx outcome
   input wire rx_status_s  rx_stat     // rx outcome
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   logic quiet;
   // no frame event, so a counter other than the heartbeat one can only change by bus access
   assign quiet = ce && !tx_stat.done && !rx_stat.done;
   sequence s_rd(logic [7:0] a);
      quiet && rd && !wr && addr == a;
   endsequence
   sequence s_wr_off(logic [7:0] a);
      quiet && wr && !net_ctrl[7] && addr == a;
   endsequence
   a_idle_rdata_zero: assert property (ce && !rd |=> rdata == 32'h0)
      else $error("rdata not zero after idle cycle");
   a_narrow_upper_zero: assert property (ce && rd && addr <= 8'h34
      && addr[1:0] == 2'b00 && addr != 8'h04 && addr != 8'h18 |=> rdata[31:8] == 24'h0)
      else $error("upper bits set on 8-bit counter");
   a_wide_upper_zero: assert property (ce && rd && addr inside {8'h04, 8'h18}
      |=> rdata[31:16] == 16'h0)
      else $error("upper bits set on 16-bit counter");
   a_unmapped_reads_zero: assert property (ce && rd && addr > 8'h34 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   a_read_clears_count: assert property (s_rd(8'h04) ##1 s_rd(8'h04) |=> rdata == 32'h0)
      else $error("counter not cleared by read");
   a_write_gated_off: assert property (s_rd(8'h0c) ##1 s_wr_off(8'h0c) ##1 s_rd(8'h0c)
      |=> rdata == 32'h0)
      else $error("write took effect while disabled");
   a_write_value_masked: assert property (quiet && wr && net_ctrl[7] && addr == 8'h00
      ##1 s_rd(8'h00) |=> rdata == ($past(wdata, 2) & 32'h0000_00ff))
      else $error("written value not read back masked");
   a_rx_gated_off: assert property (s_rd(8'h20) ##1 (ce && rx_stat.done && !rx_enable
      && !tx_stat.done && !wr && !rd) ##1 s_rd(8'h20) |=> rdata == 32'h0)
      else $error("rx counter moved while receive disabled");
endmodule
bind mac_statistics_counters mac_stat_assertions #(.HB_CYCLES(HB_CYCLES)) chk (
   .clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .net_ctrl(net_ctrl), .rx_enable(rx_enable), .tx_stat(tx_stat),
   .rx_stat(rx_stat));

// ===== dv/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mac_stat_pkg::*;
   logic        clk_sys, pend = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, tx_en_pin = 1'b0;
   logic        col_pin = 1'b0, rx_enable = 1'b1, half_duplex = 1'b1, ce = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = '0, rdata, exp_nxt = '0, pexp = '0;
   logic [31:0] net_ctrl = 32'h0000_0080, net_cfg = '0;
   tx_status_s  tx_stat = '0;
   rx_status_s  rx_stat = '0;
   int          miscompares = 0, n_checks = 0;
   mac_statistics_counters #(.HB_CYCLES(8)) uut (
      .clk_sys(clk_sys), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .net_ctrl(net_ctrl), .net_cfg(net_cfg),
      .rx_enable(rx_enable), .half_duplex(half_duplex), .tx_stat(tx_stat),
      .rx_stat(rx_stat), .tx_en_pin(tx_en_pin), .col_pin(col_pin));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // ********
   // bus access and checking
   // ********
   task automatic check(logic [31:0] seen, logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         miscompares++;
         $display("[ERR] %0t: read %h expected %h", $time, seen, want);
      end
   endtask
   // read data stands one cycle after the strobe, so compare one edge later
   always @(posedge clk_sys) begin
      if (pend) check(rdata, pexp);
      pend <= rd;
      pexp <= exp_nxt;
   end
   task automatic cyc(logic w, logic r, logic [7:0] a, logic [31:0] d,
                      tx_status_s t, rx_status_s x, logic [31:0] e);
      wr <= w;
      rd <= r;
      addr <= a;
      wdata <= d;
      tx_stat <= t;
      rx_stat <= x;
      exp_nxt <= e;
      @(posedge clk_sys);
   endtask
   task automatic rd_reg(logic [7:0] a, logic [31:0] e);
      cyc(1'b0, 1'b1, a, '0, '0, '0, e);
   endtask
   task automatic wr_reg(logic [7:0] a, logic [31:0] d);
      cyc(1'b1, 1'b0, a, d, '0, '0, '0);
   endtask
   task automatic idle(int n);
      repeat (n) cyc(1'b0, 1'b0, 8'h00, '0, '0, '0, '0);
   endtask
   // reading every counter also clears it for the next case
   task automatic chk_all(logic [13:0] m);
      for (int i = 0; i < 14; i++) rd_reg(8'(i * 4), {31'h0, m[i]});
   endtask
   task automatic txc(logic [5:0] f, logic [13:0] m);
      cyc(1'b0, 1'b0, 8'h00, '0, {1'b1, f}, '0, '0);
      chk_all(m);
   endtask
   task automatic rxc(logic [13:0] n, logic [5:0] f, logic [15:0] lf, logic [13:0] m);
      cyc(1'b0, 1'b0, 8'h00, '0, '0, {1'b1, n, f, lf}, '0);
      chk_all(m);
   endtask
   task automatic hb(logic c, logic [13:0] m);
      tx_en_pin <= 1'b1;
      idle(4);
      tx_en_pin <= 1'b0;
      idle(4);
      col_pin <= c;
      idle(2);
      col_pin <= 1'b0;
      idle(20);
      chk_all(m);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      miscompares++;
      conclude();
   end
   // ********
   // tests
   // ********
   initial begin
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      chk_all(14'h0000);
      txc(6'b100000, 14'h0002);
      txc(6'b110000, 14'h0000);
      txc(6'b100010, 14'h0010);
      txc(6'b011000, 14'h0004);
      txc(6'b010100, 14'h0008);
      txc(6'b101011, 14'h0010);
      txc(6'b000001, 14'h0020);
      txc(6'b010001, 14'h0000);
      half_duplex <= 1'b0;
      txc(6'b000001, 14'h0000);
      // enable low must swallow a frame event entirely
      ce <= 1'b0;
      cyc(1'b0, 1'b0, 8'h00, '0, 7'b1100000, '0, '0);
      ce <= 1'b1;
      chk_all(14'h0000);
      $display("test tx done");
      rxc(14'd100, 6'b110000, 16'h0800, 14'h0001);
      rxc(14'd64, 6'b110000, 16'h0800, 14'h0001);
      rxc(14'd63, 6'b110000, 16'h0800, 14'h0000);
      rxc(14'd100, 6'b101000, 16'h0800, 14'h0101);
      rxc(14'd100, 6'b001000, 16'h0800, 14'h0100);
      rxc(14'd1519, 6'b001000, 16'h0800, 14'h0500);
      rxc(14'd1519, 6'b000000, 16'h0800, 14'h0200);
      rxc(14'd1518, 6'b000000, 16'h0800, 14'h0000);
      rxc(14'd1519, 6'b010000, 16'h0800, 14'h0400);
      rxc(14'd63, 6'b000000, 16'h0800, 14'h0800);
      rxc(14'd100, 6'b000110, 16'h0800, 14'h0040);
      rxc(14'd100, 6'b000101, 16'h0800, 14'h0080);
      rxc(14'd100, 6'b000000, 16'd200, 14'h0000);
      net_cfg <= 32'h0001_0100;
      rxc(14'd1536, 6'b110000, 16'h0800, 14'h0001);
      rxc(14'd1537, 6'b000000, 16'h0800, 14'h0200);
      rxc(14'd100, 6'b000000, 16'd200, 14'h2000);
      rxc(14'd100, 6'b000000, 16'h0600, 14'h0000);
      net_cfg <= 32'h0001_0000;
      rxc(14'd1520, 6'b000000, 16'd1530, 14'h0200);
      rx_enable <= 1'b0;
      rd_reg(8'h20, 32'h0);
      cyc(1'b0, 1'b0, 8'h00, '0, '0, {1'b1, 14'd100, 6'b101000, 16'h0800}, '0);
      rd_reg(8'h20, 32'h0);
      chk_all(14'h0000);
      rx_enable <= 1'b1;
      repeat (300) cyc(1'b0, 1'b0, 8'h00, '0, '0, {1'b1, 14'd100, 6'b110000, 16'h0800}, '0);
      rd_reg(8'h00, 32'h0000_00ff);
      rd_reg(8'h00, 32'h0);
      $display("test rx done");
      wr_reg(8'h04, 32'h1234_abcd);
      rd_reg(8'h04, 32'h0000_abcd);
      rd_reg(8'h04, 32'h0);
      wr_reg(8'h00, 32'h0000_01ff);
      rd_reg(8'h00, 32'h0000_00ff);
      net_ctrl <= 32'h0;
      rd_reg(8'h0c, 32'h0);
      wr_reg(8'h0c, 32'h0000_0005);
      rd_reg(8'h0c, 32'h0);
      rd_reg(8'h38, 32'h0);
      wr_reg(8'h3c, 32'hffff_ffff);
      chk_all(14'h0000);
      $display("test registers done");
      half_duplex <= 1'b1;
      hb(1'b0, 14'h1000);
      hb(1'b1, 14'h0000);
      half_duplex <= 1'b0;
      hb(1'b0, 14'h0000);
      $display("test heartbeat done");
      idle(3);
      conclude();
   end
endmodule
